// ---- src/psgc_cmd_if.sv ----
// Purpose: command bundle from the register file to the pin driver
// Assumes: single pclk domain
// Notes: carries requested pin levels and the applied levels back
`timescale 1ns/100ps
interface psgc_cmd_if;
  import psgc_pkg::*;
  psgc_level_type want_pwm;
  psgc_level_type want_skip;
  logic want_enable;
  logic own_zcd;
  psgc_level_type pwm;
  psgc_level_type skip;
  logic enable;
  modport regs (output want_pwm, want_skip, want_enable, own_zcd, input pwm, skip, enable);
  modport pins (input want_pwm, want_skip, want_enable, own_zcd, output pwm, skip, enable);
endinterface

// ---- src/psgc_pin_drive.sv ----
// Purpose: turns requested levels into legal pin levels for the stage
// Assumes: requests are stable for a cycle at least
// Notes: skip level is pinned by the zero-current ownership choice
`timescale 1ns/100ps
module psgc_pin_drive (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // commands
  psgc_cmd_if.pins cmd
);
  import psgc_pkg::*;

  // ===========================================================
  // skip select
  // own detection low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd.skip <= PSGC_LVL_HIGH;
    end else if (cmd.own_zcd) begin
      cmd.skip <= PSGC_LVL_LOW;
    end else if (cmd.want_skip == PSGC_LVL_MID) begin
      cmd.skip <= PSGC_LVL_MID;
    end else begin
      cmd.skip <= PSGC_LVL_HIGH;
    end
  end

  // ===========================================================
  // modulation level
  // high low or mid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd.pwm <= PSGC_LVL_LOW;
    end else if (cmd.want_pwm == PSGC_LVL_HIGH || cmd.want_pwm == PSGC_LVL_MID) begin
      cmd.pwm <= cmd.want_pwm;
    end else begin
      cmd.pwm <= PSGC_LVL_LOW;
    end
  end

  // ===========================================================
  // enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd.enable <= 1'b0;
    end else begin
      cmd.enable <= cmd.want_enable;
    end
  end
endmodule

// ---- src/psgc_pkg.sv ----
// Purpose: shared constants and types for the power stage gate controller
// Assumes: 50 MHz pclk, 32-bit apb data
// Notes: level codes are the two-bit forms of the three-level pins
package psgc_pkg;
  // three-level pin codes
  typedef enum logic [1:0] {
    PSGC_LVL_LOW = 2'b00,
    PSGC_LVL_MID = 2'b01,
    PSGC_LVL_HIGH = 2'b11
  } psgc_level_type;

  // register map, byte addresses
  localparam logic [11:0] PSGC_CTRL_ADDR = 12'h000;
  localparam logic [11:0] PSGC_STAT_ADDR = 12'h004;
  localparam logic [11:0] PSGC_CAL_ADDR = 12'h008;

  // control fields
  localparam int PSGC_CTRL_EN_BIT = 0;
  localparam int PSGC_CTRL_PWM_LSB = 1;
  localparam int PSGC_CTRL_SKIP_LSB = 3;
  localparam int PSGC_CTRL_OWNZCD_BIT = 5;
  localparam logic [31:0] PSGC_CTRL_RESET = 32'h0000_0018;

  // status fields
  localparam int PSGC_STAT_WARN_BIT = 0;
  localparam int PSGC_STAT_CAL_BIT = 1;
  localparam int PSGC_STAT_PWM_LSB = 2;
  localparam int PSGC_STAT_SKIP_LSB = 4;

  // timing
  localparam int PSGC_CLK_MHZ = 50;
  localparam int PSGC_CAL_US = 25;
  localparam int PSGC_CAL_CYCLES = PSGC_CAL_US * PSGC_CLK_MHZ;
  localparam int PSGC_CNT_W = 16;

  // calibration sequencer states, gray coded
  typedef enum logic [1:0] {
    PSGC_ST_OFF = 2'b00,
    PSGC_ST_CAL = 2'b01,
    PSGC_ST_RUN = 2'b11
  } psgc_state_type;
endpackage

// ---- src/psgc_top.sv ----
// Purpose: controller that drives a buck power stage through its pins
// Assumes: apb slave for software, stage pins synchronous to pclk
// Notes: the stage sees two-bit level codes, analog levels made outside
`timescale 1ns/100ps
module psgc_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // stage pins
  output psgc_pkg::psgc_level_type pwm_level,
  output psgc_pkg::psgc_level_type skip_mode_sel,
  output logic drive_enable_n,
  input wire logic thermal_warn_n_in,
  output logic thermal_warn_n_out,
  output logic thermal_warn_n_oe,
  // controller side detection input
  input wire logic zero_current_detect
);
  import psgc_pkg::*;

  psgc_cmd_if cmd ();
  psgc_state_type state;
  logic [31:0] ctrl;
  logic [PSGC_CNT_W-1:0] cal_count;
  logic warn;
  logic access;
  logic known;
  logic wr_ctrl;
  logic rd_setup;
  logic [31:0] next_ctrl;
  logic [31:0] status_word;
  logic cal_done;
  logic zero_cut;
  psgc_state_type next_state;

  psgc_pin_drive u_pins (
    .pclk(pclk),
    .presetn(presetn),
    .cmd(cmd.pins)
  );

  // ===========================================================
  // apb slave, zero wait states
  assign access = psel && penable;
  assign pready = 1'b1;
  assign known = (paddr == PSGC_CTRL_ADDR) || (paddr == PSGC_STAT_ADDR) ||
                 (paddr == PSGC_CAL_ADDR);
  assign pslverr = access && !known;
  // a write lands in its access cycle, read data is loaded in setup
  assign wr_ctrl = access && pwrite && (paddr == PSGC_CTRL_ADDR);
  assign rd_setup = psel && !penable && !pwrite;

  // only the defined control fields are kept, the rest read as zero
  always_comb begin
    next_ctrl = '0;
    next_ctrl[PSGC_CTRL_EN_BIT] = pwdata[PSGC_CTRL_EN_BIT];
    next_ctrl[PSGC_CTRL_PWM_LSB +: 2] = pwdata[PSGC_CTRL_PWM_LSB +: 2];
    next_ctrl[PSGC_CTRL_SKIP_LSB +: 2] = pwdata[PSGC_CTRL_SKIP_LSB +: 2];
    next_ctrl[PSGC_CTRL_OWNZCD_BIT] = pwdata[PSGC_CTRL_OWNZCD_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= PSGC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= next_ctrl;
    end
  end

  // ===========================================================
  // status word
  // reports the levels handed to the pins, not the raw requests
  always_comb begin
    status_word = '0;
    status_word[PSGC_STAT_WARN_BIT] = warn;
    status_word[PSGC_STAT_CAL_BIT] = (state == PSGC_ST_CAL);
    status_word[PSGC_STAT_PWM_LSB +: 2] = cmd.pwm;
    status_word[PSGC_STAT_SKIP_LSB +: 2] = cmd.skip;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (paddr)
        PSGC_CTRL_ADDR: begin
          prdata <= ctrl;
        end
        PSGC_STAT_ADDR: begin
          prdata <= status_word;
        end
        PSGC_CAL_ADDR: begin
          prdata <= {{(32-PSGC_CNT_W){1'b0}}, cal_count};
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ===========================================================
  // commands to the pin driver
  // unknown level codes are cast through and mapped by the pin driver
  assign cmd.want_pwm = psgc_level_type'(ctrl[PSGC_CTRL_PWM_LSB +: 2]);
  assign cmd.want_skip = psgc_level_type'(ctrl[PSGC_CTRL_SKIP_LSB +: 2]);
  assign cmd.own_zcd = ctrl[PSGC_CTRL_OWNZCD_BIT];
  assign cmd.want_enable = ctrl[PSGC_CTRL_EN_BIT];

  // ===========================================================
  // calibration wait after every enable rise
  // the stage ignores modulation while it calibrates, so hold pwm low
  assign cal_done = (cal_count == '0);

  always_comb begin
    next_state = state;
    case (state)
      PSGC_ST_OFF: begin
        if (cmd.enable) begin
          next_state = PSGC_ST_CAL;
        end
      end
      PSGC_ST_CAL: begin
        if (!cmd.enable) begin
          next_state = PSGC_ST_OFF;
        end else if (cal_done) begin
          next_state = PSGC_ST_RUN;
        end
      end
      PSGC_ST_RUN: begin
        if (!cmd.enable) begin
          next_state = PSGC_ST_OFF;
        end
      end
      default: begin
        next_state = PSGC_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PSGC_ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // loads on entry to calibration, stops at zero; a drop of enable
  // mid-count abandons it and the next rise starts a full wait again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_count <= '0;
    end else if (state == PSGC_ST_OFF && cmd.enable) begin
      cal_count <= PSGC_CNT_W'(PSGC_CAL_CYCLES);
    end else if (state == PSGC_ST_CAL && cmd.enable && !cal_done) begin
      cal_count <= cal_count - 1'b1;
    end
  end

  // ===========================================================
  // pins
  // mid on zero current
  // own detection cuts the low side one cycle after zero current is seen
  assign zero_cut = cmd.own_zcd && zero_current_detect && (cmd.pwm == PSGC_LVL_LOW);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_level <= PSGC_LVL_LOW;
    end else if (state != PSGC_ST_RUN) begin
      pwm_level <= PSGC_LVL_LOW;
    end else if (zero_cut) begin
      pwm_level <= PSGC_LVL_MID;
    end else begin
      pwm_level <= cmd.pwm;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_mode_sel <= PSGC_LVL_HIGH;
      drive_enable_n <= 1'b0;
    end else begin
      skip_mode_sel <= cmd.skip;
      // enable pin high means stage may drive
      drive_enable_n <= cmd.enable;
    end
  end

  // warning pin is an input from the stage; never driven by us
  assign thermal_warn_n_out = 1'b1;
  assign thermal_warn_n_oe = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn <= 1'b0;
    end else begin
      warn <= !thermal_warn_n_in;
    end
  end
endmodule

// ---- tb/psgc_stage_model.sv ----
// Purpose: behavioural power stage facing the controller
// Assumes: level codes and comparator flags sampled on pclk
// Notes: warning is an open-drain pull, resolved by the bench
`timescale 1ns/100ps
module psgc_stage_model #(
  // 80 ns debounce plus 250 ns blanking, in whole 20 ns cycles
  parameter int WAIT_CYCLES = 17
) (
  // clock and controller pins
  input wire logic pclk,
  input wire psgc_pkg::psgc_level_type pwm_level,
  input wire psgc_pkg::psgc_level_type skip_mode_sel,
  input wire logic drive_enable_n,
  // comparator flags
  input wire logic supply_ok_flag,
  input wire logic hot_warn,
  input wire logic hot_shut,
  input wire logic switch_node_sense,
  // gates and warning
  output logic high_side_gate,
  output logic low_side_gate,
  output logic warn_pull_low
);
  import psgc_pkg::*;
  int wait_cnt;
  logic seen, run;
  assign run = supply_ok_flag && drive_enable_n && !hot_shut;
  assign warn_pull_low = hot_warn;
  always_ff @(posedge pclk) begin
    wait_cnt <= pwm_level != PSGC_LVL_MID ? WAIT_CYCLES : wait_cnt - (wait_cnt > 0);
    seen <= pwm_level == PSGC_LVL_MID && (seen || switch_node_sense);
  end
  always_ff @(posedge pclk) begin
    high_side_gate <= run && pwm_level == PSGC_LVL_HIGH && !low_side_gate;
    low_side_gate <= run && !high_side_gate && (pwm_level == PSGC_LVL_LOW
      || pwm_level == PSGC_LVL_MID && skip_mode_sel != PSGC_LVL_LOW && (wait_cnt > 0 || !seen));
  end
endmodule

// ---- tb/psgc_top_chk.sv ----
// Purpose: port checks of the gate controller
// Assumes: one pclk domain
// Notes: bound to psgc_top after the module
`timescale 1ns/100ps
module psgc_top_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // stage pins
  input wire psgc_pkg::psgc_level_type pwm_level,
  input wire psgc_pkg::psgc_level_type skip_mode_sel,
  input wire logic drive_enable_n
);
  import psgc_pkg::*;
  logic acc, hit, cw;
  assign acc = psel && penable;
  assign hit = paddr inside {PSGC_CTRL_ADDR, PSGC_STAT_ADDR, PSGC_CAL_ADDR};
  assign cw = acc && pwrite && paddr == PSGC_CTRL_ADDR;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====================
  // assertions
  chk_ready_in_access: assert property (acc |-> pready) else $error("no ready");
  chk_unmapped_err: assert property (acc && !hit |-> pslverr) else $error("no slave error");
  chk_mapped_ok: assert property (acc && hit |-> !pslverr) else $error("false slave error");
  chk_level_codes: assert property (
    pwm_level inside {PSGC_LVL_LOW, PSGC_LVL_MID, PSGC_LVL_HIGH}
    && skip_mode_sel inside {PSGC_LVL_LOW, PSGC_LVL_MID, PSGC_LVL_HIGH}) else $error("bad code");
  chk_skip_reset_high: assert property (
    $rose(presetn) |-> skip_mode_sel == PSGC_LVL_HIGH) else $error("skip not high");
  chk_cal_holds_low: assert property (
    $rose(drive_enable_n) |-> pwm_level == PSGC_LVL_LOW [*8]) else $error("pwm moved in cal");
  chk_disable_write: assert property (
    cw && !pwdata[0] |-> ##[1:4] !drive_enable_n) else $error("stage stays enabled");
  chk_own_skip_low: assert property (
    cw && pwdata[5] |-> ##[1:4] skip_mode_sel == PSGC_LVL_LOW) else $error("skip not low");
endmodule

bind psgc_top psgc_top_chk psgc_top_chk_i (.*);

// ---- tb/psgc_top_tb_top.sv ----
// Purpose: self-checking bench of the gate controller
// Assumes: zero-wait apb slave, one pclk domain
// Notes: gate expectations follow the stage decode tables
`timescale 1ns/100ps
module psgc_top_tb_top;
  import psgc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic supply_ok_flag = 1'b1, hot_warn = 1'b0, hot_shut = 1'b0, switch_node_sense = 1'b0;
  logic zero_current_detect = 1'b0, pready, pslverr, err, el, drive_enable_n;
  logic thermal_warn_n_out, thermal_warn_n_oe, high_side_gate, low_side_gate, warn_pull_low;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  psgc_level_type pwm_level, skip_mode_sel;
  psgc_level_type lv[3] = '{PSGC_LVL_HIGH, PSGC_LVL_LOW, PSGC_LVL_MID};
  psgc_level_type sk[2] = '{PSGC_LVL_HIGH, PSGC_LVL_LOW};
  int errors = 0, comparisons = 0, cycles = 0;
  // open-drain warning line with pull-up
  wire thermal_warn_n_in = !(warn_pull_low || !thermal_warn_n_oe && !thermal_warn_n_out);
  psgc_top psgc_top_i (.*);
  psgc_stage_model psgc_stage_model_i (.*);
  initial forever #10 pclk = ~pclk;
  // one calibration plus sweeps stays far below this
  always @(posedge pclk) if (++cycles == 20000) begin
    errors++;
    summarize();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) errors++;
    if (seen !== exp) $display("unexpected at %0t: %h expected %h", $time, seen, exp);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {err, q} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task automatic gates(input logic h, input logic l);
    repeat (6) @(posedge pclk);
    check(high_side_gate, h);
    check(low_side_gate, l);
  endtask
  task automatic summarize();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, PSGC_CTRL_ADDR, 32'h0000_0000);
    check(q, PSGC_CTRL_RESET);
    check(skip_mode_sel, PSGC_LVL_HIGH);
    apb(1'b0, 12'h00c, 32'h0000_0000);
    check({err, q[30:0]}, 32'h8000_0000);
    apb(1'b1, PSGC_CTRL_ADDR, 32'h0000_001f);
    repeat (4) @(posedge pclk);
    // count loads two edges after the write; three ticks gone by the setup edge
    apb(1'b0, PSGC_CAL_ADDR, 32'h0000_0000);
    check(q, PSGC_CAL_CYCLES - 3);
    do apb(1'b0, PSGC_STAT_ADDR, 32'h0000_0000); while (q[PSGC_STAT_CAL_BIT] !== 1'b0);
    check(drive_enable_n, 1'b1);
    foreach (sk[s]) foreach (lv[i]) begin
      // the pin driver only puts skip low under own detection
      apb(1'b1, PSGC_CTRL_ADDR, {26'h000_0000, s == 1, sk[s], lv[i], 1'b1});
      // mid with skip high keeps the low side on through the wait
      el = lv[i] == PSGC_LVL_LOW || lv[i] == PSGC_LVL_MID && s == 0;
      gates(lv[i] == PSGC_LVL_HIGH, el);
      if (s == 0 && i == 2) begin
        switch_node_sense <= 1'b1;
        gates(1'b0, 1'b1);
        repeat (12) @(posedge pclk);
        check(low_side_gate, 1'b0);
        switch_node_sense <= 1'b0;
      end
    end
    apb(1'b1, PSGC_CTRL_ADDR, 32'h0000_001f);
    hot_warn <= 1'b1;
    gates(1'b1, 1'b0);
    apb(1'b0, PSGC_STAT_ADDR, 32'h0000_0000);
    check(q[PSGC_STAT_WARN_BIT], 1'b1);
    hot_shut <= 1'b1;
    gates(1'b0, 1'b0);
    {hot_warn, hot_shut} <= 2'b00;
    gates(1'b1, 1'b0);
    apb(1'b0, PSGC_STAT_ADDR, 32'h0000_0000);
    check(q[PSGC_STAT_WARN_BIT], 1'b0);
    supply_ok_flag <= 1'b0;
    gates(1'b0, 1'b0);
    supply_ok_flag <= 1'b1;
    apb(1'b1, PSGC_CTRL_ADDR, 32'h0000_0021);
    gates(1'b0, 1'b1);
    check(skip_mode_sel, PSGC_LVL_LOW);
    zero_current_detect <= 1'b1;
    gates(1'b0, 1'b0);
    check(pwm_level, PSGC_LVL_MID);
    apb(1'b1, PSGC_CTRL_ADDR, 32'h0000_0000);
    gates(1'b0, 1'b0);
    check(drive_enable_n, 1'b0);
    summarize();
  end
endmodule
